// file: rtl/srac_pkg.sv
// Purpose: Shared constants for the soft reset and analog control block.
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word.
// Notes: Offsets are full byte addresses on the register bus.

package srac_pkg;

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [31:0] ANA_CTRL_ADDR = 32'h4002_000c; // Analog common control
	localparam logic [31:0] STATUS_ADDR = 32'he004_201c; // Subsystem status
	localparam logic [31:0] SOFT_RST_ADDR = 32'he004_2030; // Soft reset control

	// ************************************************************
	// Analog common control fields
	// ************************************************************
	localparam int ANA_REF_SEL_BIT = 0; // Reference select
	localparam int ANA_ALL_CLR_BIT = 1; // Common converter clear, self clearing
	localparam int ANA_ALL_PD_BIT = 2; // Common converter power down
	localparam int ANA_PWR_UP_BIT = 3; // Analog block power
	localparam int ANA_BLK_CLR_BIT = 4; // Analog control block clear, write only
	localparam logic [7:0] ANA_RESET_VAL = 8'h01; // Value after reset
	localparam logic [7:0] ANA_STORE_MASK = 8'hef; // Bits held in flip-flops

	// ************************************************************
	// Soft reset control fields
	// ************************************************************
	localparam int SR_ENGINE_BIT = 13; // Analog engine hold
	localparam int SR_IO_BIT = 14; // I/O block hold
	localparam int SR_INAPP_BIT = 15; // In-application programmer hold
	localparam int SR_PAD_HOLD_BIT = 16; // External pad hold
	localparam int SR_FABRIC_HOLD_BIT = 17; // Fabric reset output hold
	localparam int SR_FABRIC_EN_BIT = 18; // Fabric reset request enable
	localparam int SR_PAD_MON_BIT = 19; // Pad monitor enable
	localparam logic [31:0] SOFT_RESET_VAL = 32'h0003_fff8; // Value after reset
	localparam logic [31:0] SOFT_STORE_MASK = 32'hffff_e000; // Bits held here

	// ************************************************************
	// Subsystem status fields
	// ************************************************************
	localparam int ST_HIGH_BO_BIT = 0; // High supply brownout
	localparam int ST_LOW_BO_BIT = 1; // Low supply brownout
	localparam int ST_SEQ_LSB = 8; // Sequencer state field, two bits
	localparam logic [31:0] STATUS_RESET_VAL = 32'h0000_0000; // Value after reset

	// ************************************************************
	// Sequencer timing and bus answers
	// ************************************************************
	localparam int SEQ_HOLD_CYCLES = 8; // Subsystem clock periods of reset
	localparam logic [2:0] SEQ_LAST = 3'(SEQ_HOLD_CYCLES - 1); // Last count
	localparam logic [1:0] RESP_OKAY = 2'h0; // Normal answer
	localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address answer

	// Reset sequencer states
	typedef enum logic [1:0] {
		SRAC_PRESTART = 2'b00,
		SRAC_PAD_HELD = 2'b01,
		SRAC_WAIT_MON = 2'b10,
		SRAC_IDLE = 2'b11
	} srac_state_t;

endpackage

// file: rtl/srac_sync.sv
// Purpose: Two flip-flop synchroniser for signals from outside the clock domain.
// Assumes: Synchronous active low reset.
// Notes: The first stage feeds only the second stage.

`timescale 1ns/10ps

module srac_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Asynchronous input and synchronised output
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff; // First stage, read only by the second

	// ************************************************************
	// Two stages
	// ************************************************************
	// Shift the input through both stages
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end

endmodule

// file: rtl/srac_top.sv
// Purpose: Soft reset, reset sequencer and analog control registers.
// Assumes: One clock; AXI4-Lite slave with one write and one read in flight.
// Notes: Analog self-clearing bits last one clock cycle.

`timescale 1ns/10ps

module srac_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// Write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address channel
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// Read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// External reset pad, open drain
	input wire logic external_pad_reset_low_in,
	output logic external_pad_reset_low_out,
	output logic pad_output_enable_n,
	// Fabric reset signals
	input wire logic fabric_to_subsys_rst_low,
	output logic subsys_to_fabric_rst_low,
	// Issued resets
	output logic subsys_rst_low,
	output logic inapp_programmer_rst_low,
	output logic io_block_rst_low,
	output logic analog_engine_rst_low,
	// Analog block control
	output logic analog_ctrl_block_clear,
	output logic analog_power_up,
	output logic converter_reference_select,
	input wire logic [2:0] single_converter_clear,
	input wire logic [2:0] single_converter_powerdown,
	output logic [2:0] converter_clear,
	output logic [2:0] converter_powerdown,
	// Supply monitor
	input wire logic high_supply_brownout,
	input wire logic low_supply_brownout
);

	import srac_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic aw_held_ff, w_held_ff; // Write address and data captured
	logic [31:0] awaddr_ff, wdata_ff; // Captured write payload
	logic [3:0] wstrb_ff; // Captured byte enables
	logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid; // Channel next states
	logic do_write; // Write performed this cycle
	logic [31:0] strb_mask; // Byte enables widened to bits
	logic [31:0] ana_wr_word; // Merged write for analog register
	logic [31:0] soft_wr_word; // Merged write for soft reset register
	logic wr_ana, wr_soft, wr_hit; // Write decode
	logic [7:0] ana_ff; // Analog common control storage
	logic [31:0] soft_ff; // Soft reset control storage
	logic blk_clr_ff; // Analog control block clear pulse
	logic [31:0] rd_word; // Read mux
	logic rd_hit; // Read decode
	logic pad_in_s, fabric_in_s; // Synchronised reset inputs
	logic [1:0] bo_s; // Synchronised brownout flags
	srac_state_t state_ff, nxt_state; // Reset sequencer
	logic [2:0] cnt_ff; // Prestart cycle count
	logic in_prestart; // Sequencer asserting issued resets
	logic fabric_req, pad_req; // Qualified restart requests

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	srac_sync #(.W(2), .RST_VAL(2'b11)) u_sync_rst (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({external_pad_reset_low_in, fabric_to_subsys_rst_low}),
		.q({pad_in_s, fabric_in_s})
	);

	srac_sync #(.W(2), .RST_VAL(2'b00)) u_sync_bo (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({low_supply_brownout, high_supply_brownout}),
		.q(bo_s)
	);

	// ************************************************************
	// Reset sequencer
	// ************************************************************
	assign in_prestart = (state_ff == SRAC_PRESTART);
	// Fabric request only when enabled and outside prestart
	assign fabric_req = soft_ff[SR_FABRIC_EN_BIT] && !fabric_in_s && !in_prestart;
	// Pad watched only in idle, enabled, and while we do not drive it
	assign pad_req = (state_ff == SRAC_IDLE) && soft_ff[SR_PAD_MON_BIT]
		&& !soft_ff[SR_PAD_HOLD_BIT] && !pad_in_s;

	// Next state of the sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SRAC_PRESTART: begin
				// Hold issued resets for the full count
				if (cnt_ff == SEQ_LAST) begin
					nxt_state = SRAC_PAD_HELD;
				end
			end
			SRAC_PAD_HELD: begin
				// Wait for software to release the pad
				if (!soft_ff[SR_PAD_HOLD_BIT]) begin
					nxt_state = SRAC_WAIT_MON;
				end
			end
			SRAC_WAIT_MON: begin
				// Debounce window ends when monitoring is enabled
				if (soft_ff[SR_PAD_MON_BIT]) begin
					nxt_state = SRAC_IDLE;
				end
			end
			SRAC_IDLE: begin
				// Pad request restarts, disabled monitor steps back
				if (pad_req) begin
					nxt_state = SRAC_PRESTART;
				end else if (!soft_ff[SR_PAD_MON_BIT]) begin
					nxt_state = SRAC_WAIT_MON;
				end
			end
			default: begin
				nxt_state = SRAC_PRESTART;
			end
		endcase
		// Enabled fabric request restarts from any state except prestart
		if (fabric_req) begin
			nxt_state = SRAC_PRESTART;
		end
	end

	// State register and prestart counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= SRAC_PRESTART;
			cnt_ff <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			// Counter restarts on each entry into prestart
			cnt_ff <= (in_prestart && nxt_state == SRAC_PRESTART) ? cnt_ff + 3'h1 : 3'h0;
		end
	end

	// ************************************************************
	// Write channels
	// ************************************************************
	assign do_write = aw_held_ff && w_held_ff && !bvalid;

	// Next values of handshake state
	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_w_held = w_held_ff;
		nxt_bvalid = bvalid;
		nxt_rvalid = rvalid;
		if (awvalid && awready) begin
			nxt_aw_held = 1'b1;
		end
		if (wvalid && wready) begin
			nxt_w_held = 1'b1;
		end
		if (do_write) begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
		end else if (bvalid && bready) begin
			nxt_bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			nxt_rvalid = 1'b1;
		end else if (rvalid && rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// Capture address and data, answer once both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			bvalid <= nxt_bvalid;
			awready <= !nxt_aw_held && !nxt_bvalid;
			wready <= !nxt_w_held && !nxt_bvalid;
			if (awvalid && awready) begin
				awaddr_ff <= awaddr;
			end
			if (wvalid && wready) begin
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_write) begin
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Write decode and byte merge
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			strb_mask[i*8 +: 8] = {8{wstrb_ff[i]}};
		end
		wr_ana = do_write && (awaddr_ff == ANA_CTRL_ADDR);
		wr_soft = do_write && (awaddr_ff == SOFT_RST_ADDR);
		wr_hit = (awaddr_ff == ANA_CTRL_ADDR) || (awaddr_ff == SOFT_RST_ADDR)
			|| (awaddr_ff == STATUS_ADDR);
		ana_wr_word = ({24'h00_0000, ana_ff} & ~strb_mask) | (wdata_ff & strb_mask);
		soft_wr_word = (soft_ff & ~strb_mask) | (wdata_ff & strb_mask);
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	// Soft reset control, returned to reset values during prestart
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_ff <= SOFT_RESET_VAL & SOFT_STORE_MASK;
		end else if (in_prestart) begin
			soft_ff <= SOFT_RESET_VAL & SOFT_STORE_MASK;
		end else if (wr_soft) begin
			soft_ff <= soft_wr_word & SOFT_STORE_MASK;
		end
	end

	// Analog common control, clear bits self clear unless rewritten
	always_ff @(posedge aclk) begin
		if (!aresetn || in_prestart) begin
			ana_ff <= ANA_RESET_VAL & ANA_STORE_MASK;
			blk_clr_ff <= 1'b0;
		end else if (wr_ana && strb_mask[0]) begin
			ana_ff <= ana_wr_word[7:0] & ANA_STORE_MASK;
			blk_clr_ff <= wdata_ff[ANA_BLK_CLR_BIT];
		end else begin
			ana_ff[ANA_ALL_CLR_BIT] <= 1'b0;
			blk_clr_ff <= 1'b0;
		end
	end

	// ************************************************************
	// Issued resets and analog outputs
	// ************************************************************
	// subsys_rst_low registered from next state, the other outputs from the current state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			subsys_rst_low <= 1'b0;
			inapp_programmer_rst_low <= 1'b0;
			io_block_rst_low <= 1'b0;
			analog_engine_rst_low <= 1'b0;
			subsys_to_fabric_rst_low <= 1'b0;
			pad_output_enable_n <= 1'b0;
			external_pad_reset_low_out <= 1'b0;
		end else begin
			subsys_rst_low <= (nxt_state != SRAC_PRESTART);
			inapp_programmer_rst_low <= !soft_ff[SR_INAPP_BIT] && !in_prestart;
			io_block_rst_low <= !soft_ff[SR_IO_BIT] && !in_prestart;
			analog_engine_rst_low <= !soft_ff[SR_ENGINE_BIT] && !in_prestart;
			subsys_to_fabric_rst_low <= !soft_ff[SR_FABRIC_HOLD_BIT] && !in_prestart;
			pad_output_enable_n <= !(soft_ff[SR_PAD_HOLD_BIT] || in_prestart);
			external_pad_reset_low_out <= 1'b0;
		end
	end

	// Analog block and converter controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_ctrl_block_clear <= 1'b0;
			analog_power_up <= 1'b0;
			converter_reference_select <= ANA_RESET_VAL[ANA_REF_SEL_BIT];
			converter_clear <= 3'h0;
			converter_powerdown <= 3'h0;
		end else begin
			analog_ctrl_block_clear <= blk_clr_ff;
			analog_power_up <= ana_ff[ANA_PWR_UP_BIT];
			converter_reference_select <= ana_ff[ANA_REF_SEL_BIT];
			converter_clear <= {3{ana_ff[ANA_ALL_CLR_BIT]}} | single_converter_clear;
			converter_powerdown <= {3{ana_ff[ANA_ALL_PD_BIT]}} | single_converter_powerdown;
		end
	end

	// ************************************************************
	// Read channel
	// ************************************************************
	// Read mux, unheld and write-only bits read as zero, held spare bits read back as written
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		if (araddr == ANA_CTRL_ADDR) begin
			rd_word[7:0] = ana_ff;
		end else if (araddr == SOFT_RST_ADDR) begin
			rd_word = soft_ff;
		end else if (araddr == STATUS_ADDR) begin
			rd_word = STATUS_RESET_VAL;
			rd_word[ST_HIGH_BO_BIT] = bo_s[0];
			rd_word[ST_LOW_BO_BIT] = bo_s[1];
			rd_word[ST_SEQ_LSB +: 2] = state_ff;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Take one read, answer the next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			rvalid <= nxt_rvalid;
			arready <= !nxt_rvalid;
			if (arvalid && arready) begin
				rdata <= rd_word;
				rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_blk_clr;
		blk_clr_ff |=> analog_ctrl_block_clear ##1 (!analog_ctrl_block_clear || $past(blk_clr_ff));
	endproperty
	a_blk_clr: assert property (p_blk_clr) else $error("block clear not one cycle");

	property p_power;
		(wr_ana && wstrb_ff[0] && !in_prestart) |-> ##2 analog_power_up == $past(wdata_ff[3], 2);
	endproperty
	a_power: assert property (p_power) else $error("analog power not written");

	property p_pd_or;
		##1 converter_powerdown == ($past({3{ana_ff[2]}}) | $past(single_converter_powerdown));
	endproperty
	a_pd_or: assert property (p_pd_or) else $error("power down not ORed");

	property p_all_clr;
		(ana_ff[ANA_ALL_CLR_BIT] && !wr_ana) |=> !ana_ff[ANA_ALL_CLR_BIT];
	endproperty
	a_all_clr: assert property (p_all_clr) else $error("converter clear stuck");

	property p_mon;
		(state_ff == SRAC_WAIT_MON && soft_ff[SR_PAD_MON_BIT] && !fabric_req)
			|=> state_ff == SRAC_IDLE;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor enable ignored");

	property p_fab_gate;
		(state_ff == SRAC_WAIT_MON && !soft_ff[SR_FABRIC_EN_BIT]) |=> state_ff != SRAC_PRESTART;
	endproperty
	a_fab_gate: assert property (p_fab_gate) else $error("fabric request not gated");

	property p_fab_out;
		soft_ff[SR_FABRIC_HOLD_BIT] |=> !subsys_to_fabric_rst_low;
	endproperty
	a_fab_out: assert property (p_fab_out) else $error("fabric reset not held");

	property p_pad_hold;
		soft_ff[SR_PAD_HOLD_BIT] |=> !pad_output_enable_n && !external_pad_reset_low_out;
	endproperty
	a_pad_hold: assert property (p_pad_hold) else $error("pad not driven");

	property p_periph;
		(soft_ff[SR_IO_BIT] || in_prestart) |=> !io_block_rst_low;
	endproperty
	a_periph: assert property (p_periph) else $error("io block not in reset");

	property p_eight;
		$rose(state_ff == SRAC_PRESTART) |-> (!subsys_rst_low)[*8] ##1 subsys_rst_low;
	endproperty
	a_eight: assert property (p_eight) else $error("issued reset not eight cycles");

endmodule

// file: testbench/srac_top_tb_top.sv
// Purpose: Self-checking bench for the soft reset and analog control block.
// Assumes: AXI4-Lite master tasks; inputs change by non-blocking assignment after edges.
// Notes: Pad wire is pulled up; low when the block or the bench pulls it.

`timescale 1ns/10ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module srac_top_tb_top;
	import srac_pkg::*;

	// ************************************************************
	// Signals
	// ************************************************************
	// Clock, reset and bus
	logic aclk = 0, aresetn = 0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, resp;
	// Pads, fabric, analog and supply
	logic ext_low = 0, pad_wire, pad_out, pad_oe_n, fab_in = 1, fab_out;
	logic sub_rst, inapp_rst, io_rst, eng_rst, blk_clr, pwr_up, ref_sel;
	logic [2:0] sc_in = '0, spd_in = '0, conv_clr, conv_pd;
	logic hi_bo = 0, lo_bo = 0;
	// Bench bookkeeping
	int bad_count = 0, n_checks = 0, low_cnt, clr_cnt, cclr_cnt;
	logic mon = 0;
	logic [31:0] rd;

	// Row of the ordinary case table
	typedef struct packed {
		logic [31:0] addr, wdat, rexp;
		logic [1:0] resp;
		logic [2:0] spd;
		logic [9:0] oexp; // inapp,io,engine,fabric,pad oe_n,power,ref,powerdown
	} srac_row_t;
	srac_row_t rows [12];

	// ************************************************************
	// Clock, pad wire and design
	// ************************************************************
	always #2 aclk = ~aclk;

	// Open drain pad with pull-up
	assign pad_wire = ext_low ? 1'b0 : (pad_oe_n ? 1'b1 : pad_out);

	srac_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .external_pad_reset_low_in(pad_wire),
		.external_pad_reset_low_out(pad_out), .pad_output_enable_n(pad_oe_n),
		.fabric_to_subsys_rst_low(fab_in), .subsys_to_fabric_rst_low(fab_out),
		.subsys_rst_low(sub_rst), .inapp_programmer_rst_low(inapp_rst),
		.io_block_rst_low(io_rst), .analog_engine_rst_low(eng_rst),
		.analog_ctrl_block_clear(blk_clr), .analog_power_up(pwr_up),
		.converter_reference_select(ref_sel), .single_converter_clear(sc_in),
		.single_converter_powerdown(spd_in), .converter_clear(conv_clr),
		.converter_powerdown(conv_pd), .high_supply_brownout(hi_bo),
		.low_supply_brownout(lo_bo));

	// Counts pulses and reset cycles inside a monitor window
	always @(posedge aclk) begin
		if (mon) begin
			low_cnt += !sub_rst;
			clr_cnt += blk_clr;
			cclr_cnt += (conv_clr == 3'b111);
		end
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	// Bus write; address and data offered together, released when taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1;
				awvalid <= 0;
			end
			if (wvalid && wready) begin
				w_ok = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
		@(posedge aclk);
	endtask

	// Bus read; rready held until the answer is sampled
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 0;
		@(posedge aclk);
	endtask

	// Clears counters and opens a window of n sampled edges
	task automatic watch(input int n);
		low_cnt = 0;
		clr_cnt = 0;
		cclr_cnt = 0;
		mon <= 1;
		repeat (n) @(posedge aclk);
		mon <= 0;
		@(posedge aclk);
	endtask

	// Pulls the pad or the fabric request low for n cycles
	task automatic pull(input bit pad, input int n);
		if (pad) ext_low <= 1; else fab_in <= 0;
		repeat (n) @(posedge aclk);
		ext_low <= 0;
		fab_in <= 1;
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		print_verdict();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rows = '{
			'{SOFT_RST_ADDR, 32'h0000_0000, 32'h0000_0000, RESP_OKAY, 3'h0, 10'h3e8},
			'{SOFT_RST_ADDR, 32'h0000_2000, 32'h0000_2000, RESP_OKAY, 3'h0, 10'h368},
			'{SOFT_RST_ADDR, 32'h0000_4000, 32'h0000_4000, RESP_OKAY, 3'h0, 10'h2e8},
			'{SOFT_RST_ADDR, 32'h0000_8000, 32'h0000_8000, RESP_OKAY, 3'h0, 10'h1e8},
			'{SOFT_RST_ADDR, 32'h0002_0000, 32'h0002_0000, RESP_OKAY, 3'h0, 10'h3a8},
			'{SOFT_RST_ADDR, 32'hfff0_1fff, 32'hfff0_0000, RESP_OKAY, 3'h0, 10'h3e8},
			'{SOFT_RST_ADDR, 32'h0000_0000, 32'h0000_0000, RESP_OKAY, 3'h5, 10'h3ed},
			'{ANA_CTRL_ADDR, 32'h0000_0008, 32'h0000_0008, RESP_OKAY, 3'h0, 10'h3f0},
			'{ANA_CTRL_ADDR, 32'h0000_00e1, 32'h0000_00e1, RESP_OKAY, 3'h2, 10'h3ea},
			'{ANA_CTRL_ADDR, 32'h0000_0004, 32'h0000_0004, RESP_OKAY, 3'h2, 10'h3e7},
			'{STATUS_ADDR, 32'hffff_ffff, 32'h0000_0200, RESP_OKAY, 3'h2, 10'h3e7},
			'{32'h4002_0010, 32'h0000_0001, 32'h0000_0000, RESP_SLVERR, 3'h2, 10'h3e7}};
		// Reset, then the issued reset stays low for eight cycles
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		// Window opens at the release edge: the sequencer counts from that same edge
		watch(20);
		`CHK("subsys reset cycles", 8, low_cnt)
		`CHK("reset holds", 5'b00000, {inapp_rst, io_rst, eng_rst, fab_out, pad_oe_n})
		`CHK("analog outputs", 3'b001, {blk_clr, pwr_up, ref_sel})
		axi_rd(SOFT_RST_ADDR, rd, resp);
		`CHK("soft reset value", SOFT_RESET_VAL & SOFT_STORE_MASK, rd)
		axi_rd(ANA_CTRL_ADDR, rd, resp);
		`CHK("analog value", {24'h0, ANA_RESET_VAL}, rd)
		// Table of ordinary accesses
		foreach (rows[i]) begin
			spd_in <= rows[i].spd;
			axi_wr(rows[i].addr, rows[i].wdat, resp);
			`CHK("write resp", rows[i].resp, resp)
			axi_rd(rows[i].addr, rd, resp);
			`CHK("read resp", rows[i].resp, resp)
			`CHK("read data", rows[i].rexp, rd)
			`CHK("outputs", rows[i].oexp, {inapp_rst, io_rst, eng_rst, fab_out, pad_oe_n,
				pwr_up, ref_sel, conv_pd})
		end
		// Self-clearing analog bits give one-cycle pulses
		fork
			watch(12);
			axi_wr(ANA_CTRL_ADDR, 32'h0000_0012, resp);
		join
		`CHK("block clear pulses", 1, clr_cnt)
		`CHK("common clear pulses", 1, cclr_cnt)
		axi_rd(ANA_CTRL_ADDR, rd, resp);
		`CHK("analog after clear", 32'h0000_0000, rd)
		sc_in <= 3'b010;
		repeat (3) @(posedge aclk);
		`CHK("single clear", 3'b010, conv_clr)
		sc_in <= 3'b000;
		// Brownout flags in status
		hi_bo <= 1;
		repeat (4) @(posedge aclk);
		axi_rd(STATUS_ADDR, rd, resp);
		`CHK("high brownout", 32'h0000_0201, rd)
		hi_bo <= 0;
		lo_bo <= 1;
		repeat (4) @(posedge aclk);
		axi_rd(STATUS_ADDR, rd, resp);
		`CHK("low brownout", 32'h0000_0202, rd)
		lo_bo <= 0;
		// Fabric request ignored while disabled, honoured when enabled
		fork
			watch(20);
			pull(0, 12);
		join
		`CHK("fabric gated", 0, low_cnt)
		axi_wr(SOFT_RST_ADDR, 32'h0004_0000, resp);
		fork
			watch(30);
			pull(0, 3);
		join
		`CHK("fabric reset cycles", 8, low_cnt)
		axi_rd(SOFT_RST_ADDR, rd, resp);
		`CHK("soft after restart", SOFT_RESET_VAL & SOFT_STORE_MASK, rd)
		// Pad request masked outside idle
		fork
			watch(20);
			pull(1, 12);
		join
		`CHK("pad masked held", 0, low_cnt)
		axi_wr(SOFT_RST_ADDR, 32'h0000_0000, resp);
		`CHK("pad released", 1'b1, pad_wire)
		fork
			watch(20);
			pull(1, 12);
		join
		`CHK("pad masked wait", 0, low_cnt)
		// Monitor enabled late, by read-modify-write that keeps reserved bits
		axi_rd(SOFT_RST_ADDR, rd, resp);
		axi_wr(SOFT_RST_ADDR, rd | 32'h0008_0000, resp);
		axi_rd(STATUS_ADDR, rd, resp);
		`CHK("idle state", 32'h0000_0300, rd)
		fork
			watch(30);
			pull(1, 10);
		join
		`CHK("pad reset cycles", 8, low_cnt)
		`CHK("pad held again", 1'b0, pad_oe_n)
		`CHK("pad driven low", 1'b0, pad_wire)
		// Byte lanes: only lane 2 is written, the hold bits below it stay set
		wstrb <= 4'h4;
		axi_wr(SOFT_RST_ADDR, 32'h0000_0000, resp);
		wstrb <= 4'hf;
		axi_rd(SOFT_RST_ADDR, rd, resp);
		`CHK("lane merge", 32'h0000_e000, rd)
		print_verdict();
	end

endmodule
